// *** verilog/servo_loop_defines.vh ***
// constants for the servo position loop core
// assumes a 100 MHz clock and an APB register master
`ifndef SERVO_LOOP_DEFINES_VH
`define SERVO_LOOP_DEFINES_VH
`define CLK_MHZ 100
`define TICK_US 2000
`define TICK_CYCLES (`TICK_US * `CLK_MHZ)
`define TICK_MS 2
`define A_CTRL 12'h000
`define A_ZONE 12'h004
`define A_LOOPTC 12'h008
`define A_FSVEL 12'h00C
`define A_FFPCT 12'h010
`define A_INTTC 12'h014
`define A_BACKLASH 12'h018
`define A_ERRLIM 12'h01C
`define A_CMDPOS 12'h020
`define A_CMDVEL 12'h024
`define A_ACTPOS 12'h028
`define A_STATUS 12'h02C
`define A_VELOUT 12'h030
`define A_MAXVEL 12'h034
`define A_POSERR 12'h038
`define ZONE_RST 32'h0000000A
`define LOOPTC_RST 32'h000003E8
`define FSVEL_RST 32'h00000FA0
`define FSVEL_MIN 32'h00000190
`define FSVEL_MAX 32'h000F4240
`define ERRLIM_RST 32'h00001000
`define SYNC_MARGIN 32'h000003E8
`define MAXVEL_RST 32'h0010C8E0
`define DAC_FULL 32'h00007FFF
`define INT_OFF 2'h0
`define INT_CONT 2'h1
`define INT_ZONE 2'h2
`define B_DIGITAL 0
`define B_FOLLOW 1
`define B_FOLLOWEN 2
`define B_MOVING 3
`define B_CLRERR 4
`endif

// *** verilog/servo_position_loop.v ***
// servo axis position loop: zone flag, loop gain, feedforward,
// integrator, backlash reversal compensation and error limit handling.
// assumes an APB master and actual position sampled in the clk domain.
// Operation
// - in-zone flag set when idle and error within zone window, default 10.
// - in follower tracking, zone flag depends only on error while idle.
// - zone flag held low while moving, also over following.
// - loop gain gives 63 percent response within loop time constant.
// - zero loop time constant is open loop, feedforward only.
// - analog output scaled so full scale velocity means 10 volts.
// - full scale velocity kept in 400..1000000, default 4000.
// - digital mode clamps velocity at motor maximum, no error.
// - feedforward percent of commanded velocity added, default 0.
// - integrator time constant reduces error; zero disables it.
// - integrator modes off, continuous, or only when idle.
// - backlash distance subtracted going negative, cleared to zero going positive.
// - reported actual position includes compensation distance.
// - pause generator over error limit; out of sync 1000 beyond that limit.
// - backlash compensation updated only in standard mode; follower mode keeps the last offset.
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "servo_loop_defines.vh"
module servo_position_loop
#(
   parameter TICK = `TICK_CYCLES
)
(
   input wire clk,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [31:0] feedbackPos,
   output reg signed [31:0] velCmd_r,
   output reg inZone_r,
   output reg genPause_r,
   output reg outOfSync_r
);
////////////////////////////////////////////////////////////////////////
reg [5:0] ctrl_r;
reg [31:0] zone_r;
reg [31:0] loopTc_r;
reg [31:0] fsVel_r;
reg [31:0] ffPct_r;
reg [31:0] intTc_r;
reg [31:0] backlash_r;
reg [31:0] errLim_r;
reg [31:0] maxVel_r;
reg signed [31:0] cmdPos_r;
reg signed [31:0] cmdVel_r;
reg signed [31:0] posErr_r;
reg signed [31:0] prevCmd_r;
reg signed [31:0] comp_r;
reg signed [47:0] integ_r;
reg [1:0] intMode_r;
reg [31:0] tick_r;
wire tick = (tick_r == TICK - 1);
wire acc = psel & penable;
// decode in the first access cycle so read data stand at the answer edge
wire accFirst = acc & ~pready;
// writes land only at the edge where pready is sampled high
wire wr = acc & pwrite & pready;
wire follow = ctrl_r[`B_FOLLOW];
wire moving = ctrl_r[`B_MOVING];
wire signed [31:0] actPos = $signed(feedbackPos) + comp_r;
wire signed [31:0] errNow = cmdPos_r - actPos;
wire [31:0] absErr = errNow[31] ? -errNow : errNow;
// open loop ignores feedback, so error limits are not judged there
wire openLoop = (loopTc_r == 32'h00000000);
wire overLimit = ~openLoop & (absErr > errLim_r);
wire syncLost = ~openLoop & (absErr > errLim_r + `SYNC_MARGIN);
wire clrSync = wr & (paddr == `A_CTRL) & pwdata[`B_CLRERR];
wire intOff = (intTc_r == 32'h00000000) | (intMode_r == `INT_OFF) |
   ((intMode_r == `INT_ZONE) & moving) | openLoop;
// signed step keeps negative errors from wrapping in the division
wire signed [47:0] errStep = ($signed({{16{errNow[31]}}, errNow}) *
   `TICK_MS) / 1000;
////////////////////////////////////////////////////////////////////////
// apb slave, one wait state; unmapped addresses answer pslverr
always @(posedge clk)
begin
   if (reset)
   begin
      ctrl_r <= 6'h00;
      intMode_r <= `INT_OFF;
      zone_r <= `ZONE_RST;
      loopTc_r <= `LOOPTC_RST;
      fsVel_r <= `FSVEL_RST;
      ffPct_r <= 32'h00000000;
      intTc_r <= 32'h00000000;
      backlash_r <= 32'h00000000;
      errLim_r <= `ERRLIM_RST;
      maxVel_r <= `MAXVEL_RST;
      cmdPos_r <= 32'h00000000;
      cmdVel_r <= 32'h00000000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
   end
   else
   begin
      pready <= accFirst;
      pslverr <= 1'b0;
      if (accFirst)
      begin
         case (paddr)
            `A_CTRL: prdata <= {24'h000000, intMode_r, ctrl_r};
            `A_ZONE: prdata <= zone_r;
            `A_LOOPTC: prdata <= loopTc_r;
            `A_FSVEL: prdata <= fsVel_r;
            `A_FFPCT: prdata <= ffPct_r;
            `A_INTTC: prdata <= intTc_r;
            `A_BACKLASH: prdata <= backlash_r;
            `A_ERRLIM: prdata <= errLim_r;
            `A_CMDPOS: prdata <= cmdPos_r;
            `A_CMDVEL: prdata <= cmdVel_r;
            `A_ACTPOS: prdata <= actPos;
            `A_STATUS: prdata <= {29'h00000000, outOfSync_r, genPause_r,
               inZone_r};
            `A_VELOUT: prdata <= velCmd_r;
            `A_MAXVEL: prdata <= maxVel_r;
            `A_POSERR: prdata <= posErr_r;
            default:
            begin
               prdata <= 32'h00000000;
               pslverr <= 1'b1;
            end
         endcase
      end
      if (wr)
      begin
         case (paddr)
            `A_CTRL:
            begin
               ctrl_r <= pwdata[5:0];
               intMode_r <= pwdata[7:6];
            end
            `A_ZONE: zone_r <= pwdata;
            `A_LOOPTC: loopTc_r <= pwdata;
            // out of range values saturate to the legal band
            `A_FSVEL:
            begin
               if (pwdata < `FSVEL_MIN)
                  fsVel_r <= `FSVEL_MIN;
               else if (pwdata > `FSVEL_MAX)
                  fsVel_r <= `FSVEL_MAX;
               else
                  fsVel_r <= pwdata;
            end
            `A_FFPCT: ffPct_r <= pwdata;
            `A_INTTC: intTc_r <= pwdata;
            `A_BACKLASH: backlash_r <= pwdata;
            `A_ERRLIM: errLim_r <= pwdata;
            `A_CMDPOS: cmdPos_r <= pwdata;
            `A_CMDVEL: cmdVel_r <= pwdata;
            `A_MAXVEL: maxVel_r <= pwdata;
            default: ;
         endcase
      end
   end
end
////////////////////////////////////////////////////////////////////////
// servo loop arithmetic; division kept simple at the cost of area
reg signed [63:0] loopV;
reg signed [63:0] ffV;
reg signed [63:0] intV;
reg signed [63:0] sumV;
reg signed [63:0] dacV;
reg signed [31:0] dir;
always @*
begin
   // velocity = error * 1000 / tc(ms) gives 63% in tc
   if (openLoop)
      loopV = 64'sd0;
   else
      loopV = ($signed({{32{errNow[31]}}, errNow}) * 64'sd1000) /
         $signed({32'h00000000, loopTc_r});
   ffV = ($signed({{32{cmdVel_r[31]}}, cmdVel_r}) *
      $signed({32'h00000000, ffPct_r})) / 64'sd100;
   if (intTc_r == 32'h00000000 || openLoop)
      intV = 64'sd0;
   else
      intV = ($signed({{16{integ_r[47]}}, integ_r}) * 64'sd1000) /
         $signed({32'h00000000, intTc_r});
   sumV = loopV + ffV + intV;
   // analog: full scale velocity maps to the 10 V dac code
   dacV = (sumV * $signed({32'h00000000, `DAC_FULL})) /
      $signed({32'h00000000, fsVel_r});
   dir = cmdPos_r - prevCmd_r;
end
wire signed [63:0] digVel;
wire signed [63:0] dacVel;
// digital drives clamp silently at the motor limit
sat_clamp #(.W(64)) i_digClamp
(
   .value(sumV),
   .limit({32'h00000000, maxVel_r}),
   .clamped(digVel)
);
// the dac code cannot exceed its full scale either way
sat_clamp #(.W(64)) i_dacClamp
(
   .value(dacV),
   .limit({32'h00000000, `DAC_FULL}),
   .clamped(dacVel)
);
wire signed [63:0] outV = ctrl_r[`B_DIGITAL] ? digVel : dacVel;
////////////////////////////////////////////////////////////////////////
// update tick counter: one servo update every TICK clocks
always @(posedge clk)
begin
   if (reset)
      tick_r <= 32'h00000000;
   else if (tick)
      tick_r <= 32'h00000000;
   else
      tick_r <= tick_r + 32'h00000001;
end
////////////////////////////////////////////////////////////////////////
// loop output and status flags, refreshed on each tick
always @(posedge clk)
begin
   if (reset)
   begin
      velCmd_r <= 32'h00000000;
      inZone_r <= 1'b0;
      genPause_r <= 1'b0;
      posErr_r <= 32'h00000000;
   end
   else if (tick)
   begin
      posErr_r <= errNow;
      // output drops in the very update that finds the axis out of sync
      if (outOfSync_r || syncLost)
         velCmd_r <= 32'h00000000;
      else
         velCmd_r <= outV[31:0];
      // moving forces zone low even over following
      inZone_r <= ~moving & (absErr <= zone_r);
      genPause_r <= overLimit;
   end
end
////////////////////////////////////////////////////////////////////////
// out of sync latch: a fresh breach beats a host clear in one cycle
always @(posedge clk)
begin
   if (reset)
      outOfSync_r <= 1'b0;
   else if (tick && syncLost)
      outOfSync_r <= 1'b1;
   else if (clrSync)
      outOfSync_r <= 1'b0;
end
////////////////////////////////////////////////////////////////////////
// reversal compensation follows the sign of each command change outside follower mode
always @(posedge clk)
begin
   if (reset)
   begin
      prevCmd_r <= 32'h00000000;
      comp_r <= 32'h00000000;
   end
   else if (tick)
   begin
      prevCmd_r <= cmdPos_r;
      if (!follow && dir != 32'h00000000)
      begin
         if (dir[31])
            comp_r <= -$signed(backlash_r);
         else
            comp_r <= 32'h00000000;
      end
   end
end
////////////////////////////////////////////////////////////////////////
// error integrator, emptied whenever its mode stops it
always @(posedge clk)
begin
   if (reset)
      integ_r <= 48'h000000000000;
   else if (tick)
   begin
      if (intOff)
         integ_r <= 48'h000000000000;
      else
         integ_r <= integ_r + errStep;
   end
end
endmodule
////////////////////////////////////////////////////////////////////////
// symmetric saturation: value held inside -limit..limit
module sat_clamp
#(
   parameter W = 64
)
(
   input wire signed [W-1:0] value,
   input wire signed [W-1:0] limit,
   output reg signed [W-1:0] clamped
);
always @*
begin
   if (value > limit)
      clamped = limit;
   else if (value < -limit)
      clamped = -limit;
   else
      clamped = value;
end
endmodule

// *** tb/servo_loop_asserts.sv ***
// port checker for the servo position loop
// assumes the bind in testbench and a tick of 10 or more cycles
`timescale 1ns/1ns
module servo_loop_asserts
(
   input wire clk,
   input wire reset,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr,
   input wire [31:0] feedbackPos,
   input wire signed [31:0] velCmd_r,
   input wire inZone_r,
   input wire genPause_r,
   input wire outOfSync_r
);
default clocking cb @(posedge clk); endclocking
default disable iff (reset);
chk_ready_timing: assert property (psel && penable && !pready |=> pready)
   else $error("ready late");
chk_ready_pulse: assert property (pready |=> !pready) else $error("ready long");
chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
   else $error("error data");
chk_reset_quiet: assert property (disable iff (1'b0) reset |=> !inZone_r &&
   !genPause_r && !outOfSync_r && velCmd_r == 0) else $error("reset state");
chk_sync_halts: assert property (outOfSync_r |-> velCmd_r == 0)
   else $error("sync output");
chk_sync_paused: assert property ($rose(outOfSync_r) |-> genPause_r)
   else $error("sync pause");
chk_vel_tick: assert property (
   $changed(velCmd_r) |=> $stable(velCmd_r)[*8]) else $error("vel off tick");
chk_zone_tick: assert property (
   $changed(inZone_r) |=> $stable(inZone_r)[*8]) else $error("zone off tick");
cover property ($rose(inZone_r));
cover property ($rose(outOfSync_r));
cover property (pslverr);
endmodule

// *** tb/drive_model.sv ***
// servo drive with encoder: moves the axis by the velocity command
// assumes the tick-level velocity is scaled down per clock
`timescale 1ns/1ns
module drive_model
(
   input wire clk,
   input wire reset,
   input wire run,
   input wire signed [31:0] velCmd,
   output reg [31:0] pos
);
always @(posedge clk)
   if (reset)
      pos <= 32'h000003E8;
   else if (run)
      pos <= pos + (velCmd >>> 12);
endmodule

// *** tb/testbench.sv ***
// self-checking bench for the servo position loop
// assumes tick shortened to 20 cycles
`timescale 1ns/1ns
`include "servo_loop_defines.vh"
module testbench;
logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, run = 0, er;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, rd, prdata, feedbackPos, fb;
logic pready, pslverr, inZone_r, genPause_r, outOfSync_r;
logic signed [31:0] velCmd_r;
int miscompares = 0, compares = 0, seed = 32'he6eb, v;
always #5 clk = ~clk;
servo_position_loop #(.TICK(20)) i_dut(.clk, .reset, .psel, .penable,
   .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .feedbackPos,
   .velCmd_r, .inZone_r, .genPause_r, .outOfSync_r);
drive_model i_drv(.clk, .reset, .run, .velCmd(velCmd_r), .pos(feedbackPos));
task conclude;
   $display("compares %0d miscompares %0d", compares, miscompares);
   if (miscompares == 0 && compares > 0)
      $display("STATUS OK");
   else
      $display("STATUS NOT OK");
   $finish;
endtask
task chk(input logic [31:0] g, input logic [31:0] e);
   compares++;
   if (g !== e)
   begin
      miscompares++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
   end
endtask
// one idle edge first so release and the next setup never share a step
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
   int n;
   @(posedge clk);
   psel <= 1;
   pwrite <= w;
   paddr <= a;
   pwdata <= d;
   @(posedge clk);
   penable <= 1;
   n = 0;
   do
   begin
      @(posedge clk);
      n++;
   end
   while (pready !== 1'b1 && n < 50);
   rd = prdata;
   er = pslverr;
   psel <= 0;
   penable <= 0;
endtask
task wr(input logic [11:0] a, input logic [31:0] d);
   apb(1, a, d);
endtask
task rdc(input logic [11:0] a, input logic [31:0] e);
   apb(0, a, 0);
   chk(rd, e);
endtask
task tick;
   repeat (40) @(posedge clk);
endtask
initial
begin
   repeat (20000) @(posedge clk);
   miscompares++;
   conclude;
end
initial
begin
   repeat (8) @(posedge clk);
   reset <= 0;
   rdc(`A_ZONE, `ZONE_RST);
   rdc(`A_LOOPTC, `LOOPTC_RST);
   rdc(`A_FFPCT, 0);
   rdc(`A_INTTC, 0);
   rdc(`A_BACKLASH, 0);
   rdc(`A_FSVEL, `FSVEL_RST);
   wr(`A_FSVEL, 32'h00000064);
   rdc(`A_FSVEL, `FSVEL_MIN);
   wr(`A_FSVEL, 32'h001E8480);
   rdc(`A_FSVEL, `FSVEL_MAX);
   wr(`A_FSVEL, 32'h0002222C);
   rdc(`A_FSVEL, 32'h0002222C);
   apb(0, 12'h0FC, 0);
   chk({31'h0, er}, 1);
   for (v = 2; v >= 0; v--)
   begin
      wr(`A_CTRL, (v << 6) | 1);
      rdc(`A_CTRL, (v << 6) | 1);
   end
   wr(`A_CMDPOS, 32'h000003F2);
   tick;
   chk({31'h0, inZone_r}, 1);
   chk(velCmd_r, 10);
   wr(`A_CMDPOS, 32'h000003F3);
   tick;
   chk({31'h0, inZone_r}, 0);
   wr(`A_CTRL, 32'h00000009);
   wr(`A_CMDPOS, 32'h000003F2);
   tick;
   chk({31'h0, inZone_r}, 0);
   wr(`A_CTRL, 32'h00000007);
   tick;
   chk({31'h0, inZone_r}, 1);
   wr(`A_CTRL, 1);
   wr(`A_LOOPTC, 0);
   wr(`A_FFPCT, 100);
   v = $random(seed) & 32'h000FFFFF;
   wr(`A_CMDVEL, v);
   tick;
   chk(velCmd_r, v);
   wr(`A_FFPCT, 50);
   tick;
   chk(velCmd_r, v * 50 / 100);
   wr(`A_FFPCT, 100);
   wr(`A_CMDVEL, 32'h00200000);
   run <= 1;
   tick;
   chk(velCmd_r, `MAXVEL_RST);
   run <= 0;
   tick;
   fb = feedbackPos;
   rdc(`A_ACTPOS, fb);
   wr(`A_BACKLASH, 5);
   wr(`A_CMDPOS, fb + 100);
   tick;
   rdc(`A_ACTPOS, fb);
   wr(`A_CMDPOS, fb - 100);
   tick;
   rdc(`A_ACTPOS, fb - 5);
   wr(`A_CMDPOS, fb);
   tick;
   rdc(`A_ACTPOS, fb);
   wr(`A_CTRL, 32'h00000007);
   wr(`A_CMDPOS, fb - 50);
   tick;
   rdc(`A_ACTPOS, fb);
   wr(`A_CTRL, 1);
   wr(`A_LOOPTC, `LOOPTC_RST);
   wr(`A_CMDPOS, fb + 4097);
   tick;
   chk({genPause_r, outOfSync_r}, 2);
   wr(`A_CMDPOS, fb + 5097);
   tick;
   chk({31'h0, outOfSync_r}, 1);
   chk(velCmd_r, 0);
   wr(`A_CMDPOS, fb);
   wr(`A_CTRL, 32'h00000011);
   tick;
   chk({genPause_r, outOfSync_r}, 0);
   wr(`A_INTTC, 32'h00001388);
   wr(`A_CTRL, 32'h00000081);
   tick;
   rdc(`A_INTTC, 32'h00001388);
   chk({31'h0, inZone_r}, 1);
   conclude;
end
endmodule
bind servo_position_loop servo_loop_asserts i_chk(.clk, .reset, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
   .feedbackPos, .velCmd_r, .inZone_r, .genPause_r, .outOfSync_r);
